// File: src/rtcs_pkg.sv
// Purpose: shared constants for the clock supervisor control block
// Assumes: 250 MHz ref_clk, byte-wide register port
// Notes: counts derive from printed times; long counts are top parameters
package rtcs_pkg;
  localparam logic [7:0] OFS_HALT = 8'h01;
  localparam logic [7:0] OFS_CENT = 8'h03;
  localparam logic [7:0] OFS_TREC = 8'h04;
  localparam logic [7:0] OFS_YEAR = 8'h07;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_DOG = 8'h09;
  localparam logic [7:0] OFS_ALM = 8'h0A;
  localparam logic [7:0] OFS_HTM = 8'h0C;
  localparam logic [7:0] OFS_FLAG = 8'h0F;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h11;
  localparam logic [7:0] OFS_IRQ_EN = 8'h12;
  localparam int unsigned B_CENT_EN = 7;
  localparam int unsigned B_CENT = 6;
  localparam int unsigned B_TREC = 7;
  localparam int unsigned B_HALT = 7;
  localparam int unsigned B_OUT = 7;
  localparam int unsigned B_TST = 6;
  localparam int unsigned B_APIN = 7;
  localparam int unsigned B_SQW_EN = 6;
  localparam int unsigned B_ABAK = 5;
  localparam int unsigned B_HTM = 6;
  localparam int unsigned B_WEAK = 4;
  localparam int unsigned B_PIN = 0;
  localparam int unsigned EV_WEAK = 0;
  localparam int unsigned EV_RECOV = 1;
  localparam int unsigned EV_CENT = 2;
  localparam int unsigned N_EV = 3;
  localparam logic RST_OUT = 1'b1;
  localparam logic RST_HALT = 1'b1;
  localparam logic RST_HTM = 1'b1;
  localparam logic RST_TREC = 1'b0;
  localparam logic [7:0] RST_DOG = 8'h00;
  localparam logic [7:0] RST_YEAR = 8'h00;
  localparam logic [7:0] YEAR_LAST = 8'h99;
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned REC_A_US = 96000;
  localparam int unsigned REC_B_US = 40000;
  localparam int unsigned REC_C_US = 50;
  localparam longint unsigned DAY_HOURS = 24;
  localparam longint unsigned US_PER_HOUR = 64'hD693_A400;
  localparam logic [31:0] REC_A_CYC_D = 32'(REC_A_US * CLK_MHZ);
  localparam logic [31:0] REC_B_CYC_D = 32'(REC_B_US * CLK_MHZ);
  localparam logic [31:0] REC_C_CYC_D = 32'(REC_C_US * CLK_MHZ);
  localparam logic [47:0] DAY_CYC_D = 48'(DAY_HOURS * US_PER_HOUR * CLK_MHZ);
  typedef enum logic [1:0] {PWR_BACKUP, PWR_RECOV, PWR_RUN} rtcs_pwr_t;
endpackage : rtcs_pkg

// File: src/rtcs_sync.sv
// Purpose: two-stage synchroniser for asynchronous level inputs
// Assumes: inputs are slow levels, not pulses
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
module rtcs_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk, // clock
  input wire logic rst_b, // async reset, active low
  input wire logic [W-1:0] d_i, // async levels
  output logic [W-1:0] q_o // synchronised levels
);
  logic [W-1:0] meta_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule : rtcs_sync

// File: src/rtcs_down_cnt.sv
// Purpose: loadable down counter with a one-cycle expiry pulse
// Assumes: load value of at least one
// Notes: idles at zero until loaded again
`timescale 1ns/10ps
module rtcs_down_cnt #(
  parameter int W = 32
) (
  input wire logic ref_clk, // clock
  input wire logic rst_b, // async reset, active low
  input wire logic load_i, // start a new interval
  input wire logic [W-1:0] val_i, // interval length in cycles
  output logic expire_o // pulse at interval end
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (load_i) begin
      cnt_r <= val_i;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  // no load term here: a caller that reloads on expiry would close a loop
  assign expire_o = (cnt_r == W'(1));
endmodule : rtcs_down_cnt

// File: src/rtcs_supervisor.sv
// Purpose: power sequencing, century bit, general output pin, cell check
// Assumes: analog comparators deliver async levels; year_tick is local
// Notes: registers refuse all access outside the running state
`timescale 1ns/10ps
module rtcs_supervisor
  import rtcs_pkg::*;
#(
  parameter logic [31:0] REC_A_CYC = REC_A_CYC_D, // select 0, halt 0
  parameter logic [31:0] REC_B_CYC = REC_B_CYC_D, // select 0, halt 1
  parameter logic [31:0] REC_C_CYC = REC_C_CYC_D, // select 1
  parameter logic [47:0] DAY_CYC = DAY_CYC_D // cell check interval
) (
  input wire logic ref_clk, // 250 MHz clock
  input wire logic rst_b, // async reset, active low
  input wire logic supply_ok, // supply above deselect threshold, async
  input wire logic fail_sense_low, // fail sense below reference, async
  input wire logic cell_low, // battery below weak level, async
  input wire logic year_tick, // pulse: date fields roll to new year
  input wire logic [7:0] addr, // register address
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  output logic fail_warn_output, // warning, low on failing supply
  output logic rst_out_o, // reset pin drive value, always 0
  output logic rst_out_oe, // reset pin pulled low while high
  input wire logic multi_function_pin_i, // pin level, async
  output logic multi_function_pin_o, // pin drive value, always 0
  output logic multi_function_pin_oe, // pin pulled low while high
  output logic irq // level interrupt
);
  logic [3:0] sync_q;
  logic supply_s;
  logic fail_low_s;
  logic cell_low_s;
  logic pin_s;
  rtcs_pwr_t pwr_r;
  rtcs_pwr_t pwr_nxt;
  logic pwr_up;
  logic rec_done;
  logic day_done;
  logic chk;
  logic init_pend_r;
  logic acc_ok;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] rec_len;
  logic cent_en_r;
  logic cent_r;
  logic trec_r;
  logic halt_r;
  logic out_r;
  logic tst_r;
  logic apin_r;
  logic abak_r;
  logic sqw_en_r;
  logic htm_r;
  logic weak_r;
  logic [7:0] dog_r;
  logic [7:0] year_r;
  logic cent_roll;
  logic [N_EV-1:0] ev;
  logic [N_EV-1:0] irq_st_r;
  logic [N_EV-1:0] irq_en_r;
  logic [N_EV-1:0] irq_clr;
  logic gen_mode;
  logic [7:0] rd_nxt;

  rtcs_sync #(
    .W(4)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .d_i({supply_ok, fail_sense_low, cell_low, multi_function_pin_i}),
    .q_o(sync_q)
  );

  assign supply_s = sync_q[3];
  assign fail_low_s = sync_q[2];
  assign cell_low_s = sync_q[1];
  assign pin_s = sync_q[0];

  // power state: back-up, recovery, running
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      PWR_BACKUP: begin
        if (supply_s) begin
          pwr_nxt = PWR_RECOV;
        end
      end
      PWR_RECOV: begin
        if (!supply_s) begin
          pwr_nxt = PWR_BACKUP;
        end else if (rec_done) begin
          pwr_nxt = PWR_RUN;
        end
      end
      PWR_RUN: begin
        if (!supply_s) begin
          pwr_nxt = PWR_BACKUP;
        end
      end
      default: begin
        pwr_nxt = PWR_BACKUP;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_r <= PWR_BACKUP;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  assign pwr_up = (pwr_r == PWR_BACKUP) && supply_s;
  assign acc_ok = (pwr_r == PWR_RUN);
  assign wr_ok = wr && acc_ok;
  assign rd_ok = rd && acc_ok;

  // first power-up after reset uses the initial defaults
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      init_pend_r <= 1'b1;
    end else if (pwr_up) begin
      init_pend_r <= 1'b0;
    end
  end

  // length chosen from the bits as they will stand after defaults
  always_comb begin
    if (!init_pend_r && trec_r) begin
      rec_len = REC_C_CYC;
    end else if (init_pend_r || halt_r) begin
      rec_len = REC_B_CYC;
    end else begin
      rec_len = REC_A_CYC;
    end
  end

  rtcs_down_cnt #(
    .W(32)
  ) u_rec_cnt (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .load_i(pwr_up),
    .val_i(rec_len),
    .expire_o(rec_done)
  );

  // daily interval restarts at each power-up
  rtcs_down_cnt #(
    .W(48)
  ) u_day_cnt (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .load_i(pwr_up || day_done),
    .val_i(DAY_CYC),
    .expire_o(day_done)
  );

  // no check in back-up: the daily pulse is gated by supply
  assign chk = pwr_up || (day_done && supply_s);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      weak_r <= 1'b0;
    end else if (chk) begin
      weak_r <= cell_low_s;
    end
  end

  // power-up defaults win over nothing: writes are refused then
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      trec_r <= RST_TREC;
      halt_r <= RST_HALT;
      out_r <= RST_OUT;
    end else if (pwr_up && init_pend_r) begin
      trec_r <= RST_TREC;
      halt_r <= RST_HALT;
      out_r <= RST_OUT;
    end else if (wr_ok) begin
      if (addr == OFS_TREC) begin
        trec_r <= wdata[B_TREC];
      end
      if (addr == OFS_HALT) begin
        halt_r <= wdata[B_HALT];
      end
      if (addr == OFS_CTRL) begin
        out_r <= wdata[B_OUT];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tst_r <= 1'b0;
      apin_r <= 1'b0;
      abak_r <= 1'b0;
      sqw_en_r <= 1'b0;
      dog_r <= RST_DOG;
      htm_r <= RST_HTM;
    end else if (pwr_up) begin
      tst_r <= 1'b0;
      apin_r <= 1'b0;
      abak_r <= 1'b0;
      sqw_en_r <= 1'b0;
      dog_r <= RST_DOG;
      htm_r <= RST_HTM;
    end else if (wr_ok) begin
      if (addr == OFS_CTRL) begin
        tst_r <= wdata[B_TST];
      end
      if (addr == OFS_ALM) begin
        apin_r <= wdata[B_APIN];
        sqw_en_r <= wdata[B_SQW_EN];
        abak_r <= wdata[B_ABAK];
      end
      if (addr == OFS_DOG) begin
        dog_r <= wdata;
      end
      if (addr == OFS_HTM) begin
        htm_r <= wdata[B_HTM];
      end
    end
  end

  assign cent_roll = year_tick && (year_r == YEAR_LAST);

  // a write in the rollover cycle wins: software meant that value
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      year_r <= RST_YEAR;
    end else if (wr_ok && (addr == OFS_YEAR)) begin
      year_r <= wdata;
    end else if (cent_roll) begin
      year_r <= RST_YEAR;
    end else if (year_tick) begin
      if (year_r[3:0] == BCD_NINE) begin
        year_r <= {year_r[7:4] + 4'h1, 4'h0};
      end else begin
        year_r <= {year_r[7:4], year_r[3:0] + 4'h1};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cent_en_r <= 1'b0;
      cent_r <= 1'b0;
    end else if (wr_ok && (addr == OFS_CENT)) begin
      cent_en_r <= wdata[B_CENT_EN];
      cent_r <= wdata[B_CENT];
    end else if (cent_roll && cent_en_r) begin
      cent_r <= !cent_r;
    end
  end

  // warning output per power state
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fail_warn_output <= 1'b0;
    end else begin
      case (pwr_r)
        PWR_RUN: fail_warn_output <= !fail_low_s;
        PWR_RECOV: fail_warn_output <= 1'b1;
        default: fail_warn_output <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_out_oe <= 1'b1;
    end else begin
      rst_out_oe <= (pwr_r != PWR_RUN);
    end
  end

  assign rst_out_o = 1'b0;
  assign multi_function_pin_o = 1'b0;

  // alarm, test and watchdog drives are not built here; pin releases
  assign gen_mode = !tst_r && !apin_r && (dog_r == RST_DOG);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      multi_function_pin_oe <= 1'b0;
    end else begin
      multi_function_pin_oe <= gen_mode && !out_r;
    end
  end

  // interrupt status: set beats clear in the same cycle
  assign ev[EV_WEAK] = chk && cell_low_s;
  assign ev[EV_RECOV] = rec_done && (pwr_r == PWR_RECOV) && supply_s;
  assign ev[EV_CENT] = cent_roll;
  assign irq_clr = (wr_ok && (addr == OFS_IRQ_CLR)) ? wdata[N_EV-1:0] : '0;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_st_r <= '0;
      irq_en_r <= '0;
    end else begin
      irq_st_r <= (irq_st_r & ~irq_clr) | ev;
      if (wr_ok && (addr == OFS_IRQ_EN)) begin
        irq_en_r <= wdata[N_EV-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_st_r & irq_en_r);
    end
  end

  // read path; deselected or unmapped reads return zero
  always_comb begin
    rd_nxt = 8'h00;
    case (addr)
      OFS_HALT: rd_nxt[B_HALT] = halt_r;
      OFS_CENT: rd_nxt = {cent_en_r, cent_r, 6'h00};
      OFS_TREC: rd_nxt[B_TREC] = trec_r;
      OFS_YEAR: rd_nxt = year_r;
      OFS_CTRL: rd_nxt = {out_r, tst_r, 6'h00};
      OFS_DOG: rd_nxt = dog_r;
      OFS_ALM: rd_nxt = {apin_r, sqw_en_r, abak_r, 5'h00};
      OFS_HTM: rd_nxt[B_HTM] = htm_r;
      OFS_FLAG: rd_nxt = {3'h0, weak_r, 3'h0, pin_s};
      OFS_IRQ_STAT: rd_nxt[N_EV-1:0] = irq_st_r;
      OFS_IRQ_EN: rd_nxt[N_EV-1:0] = irq_en_r;
      default: rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (rd_ok) begin
      rdata <= rd_nxt;
    end else begin
      rdata <= 8'h00;
    end
  end

  default clocking main_clk @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_warn_backup_low: assert property (
    (pwr_r == PWR_BACKUP) |=> !fail_warn_output)
    else $error("warning output not low in back-up");

  a_warn_recov_high: assert property (
    (pwr_r == PWR_RECOV) |=> fail_warn_output)
    else $error("warning output not forced high in recovery");

  a_warn_follow: assert property (
    (pwr_r == PWR_RUN) |=> (fail_warn_output == !$past(fail_low_s)))
    else $error("warning output does not follow comparator");

  a_cent_flip: assert property (
    (cent_roll && cent_en_r && !(wr_ok && addr == OFS_CENT)) |=> (cent_r != $past(cent_r)))
    else $error("century bit did not flip");

  a_cent_keep: assert property (
    (cent_roll && !cent_en_r && !(wr_ok && addr == OFS_CENT)) |=> $stable(cent_r))
    else $error("century bit changed while disabled");

  a_pin_low_drive: assert property (
    (gen_mode && !out_r) |=> multi_function_pin_oe)
    else $error("pin not pulled low in general mode");

  a_pin_release: assert property (
    out_r |=> !multi_function_pin_oe)
    else $error("pin pulled low with level bit set");

  a_weak_set: assert property (
    (chk && cell_low_s) |=> (weak_r && irq_st_r[EV_WEAK]))
    else $error("weak flag or status not set");

  a_chk_supply: assert property (
    ((pwr_r == PWR_BACKUP) && !supply_s) |=> $stable(weak_r))
    else $error("cell check without supply");

  a_write_refused: assert property (
    (wr && (pwr_r != PWR_RUN) && !pwr_up && !cent_roll) |=> ($stable(out_r) && $stable(cent_en_r) && $stable(cent_r)))
    else $error("write accepted while deselected");

  a_reset_held: assert property (
    (pwr_r == PWR_RECOV) [*2] |-> rst_out_oe)
    else $error("reset released during recovery");

  a_first_defaults: assert property (
    (pwr_up && init_pend_r) |=> (halt_r && out_r && htm_r && !trec_r && (dog_r == RST_DOG)))
    else $error("initial defaults not loaded");

  a_later_defaults: assert property (
    (pwr_up && !init_pend_r) |=> ($stable(trec_r) && $stable(out_r) && $stable(halt_r)
      && htm_r && !tst_r && !apin_r))
    else $error("later power-up defaults wrong");
endmodule : rtcs_supervisor

// File: sim/rtcs_host_model.sv
// Purpose: host side model: supply, fail divider, cell, pull-ups
// Assumes: bench sets the request levels at clock edges
// Notes: small delay keeps async levels off the sampling edge
`timescale 1ns/10ps
module rtcs_host_model (
  input wire logic supply_req, // supply wanted up
  input wire logic fail_req, // divider below reference
  input wire logic cell_req, // battery worn out
  input wire logic pin_oe, // device pulls pin low
  input wire logic rst_oe, // device pulls reset low
  output logic supply_ok, // supply above threshold
  output logic fail_sense_low, // comparator result
  output logic cell_low, // battery below weak level
  output logic pin_level, // pin wire level
  output logic rst_level // reset wire level
);
  assign #1 supply_ok = supply_req;
  assign #1 fail_sense_low = fail_req;
  assign #1 cell_low = cell_req;
  // open drain with pull-up: released means high
  assign #1 pin_level = pin_oe ? 1'b0 : 1'b1;
  assign #1 rst_level = rst_oe ? 1'b0 : 1'b1;
endmodule : rtcs_host_model

// File: sim/testbench.sv
// Purpose: self-checking bench for the supervisor block
// Assumes: short recovery and day counts set as parameters
// Notes: each scenario drives and judges before it returns
`timescale 1ns/10ps
module testbench;
  import rtcs_pkg::*;
  localparam int RA = 20;
  localparam int RB = 30;
  localparam int RC = 10;
  localparam int DAY = 200;
  localparam int S_WARN = 0;
  localparam int S_RST = 1;
  localparam int S_PIN = 2;
  localparam int S_IRQ = 3;
  logic ref_clk, rst_b, year_tick, wr, rd;
  logic [7:0] addr, wdata, rdata, rv;
  logic warn, rst_oe, rst_o, pin_lvl, rst_lvl, pin_o, pin_oe, irq;
  logic supply_req, fail_req, cell_req, supply_ok, fail_low, cell_low;
  int mismatches, comparisons;

  rtcs_supervisor #(.REC_A_CYC(32'(RA)), .REC_B_CYC(32'(RB)), .REC_C_CYC(32'(RC)), .DAY_CYC(48'(DAY))) dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .supply_ok(supply_ok), .fail_sense_low(fail_low),
    .cell_low(cell_low), .year_tick(year_tick), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .fail_warn_output(warn), .rst_out_o(rst_o), .rst_out_oe(rst_oe),
    .multi_function_pin_i(pin_lvl), .multi_function_pin_o(pin_o), .multi_function_pin_oe(pin_oe), .irq(irq));

  rtcs_host_model host (
    .supply_req(supply_req), .fail_req(fail_req), .cell_req(cell_req), .pin_oe(pin_oe), .rst_oe(rst_oe),
    .supply_ok(supply_ok), .fail_sense_low(fail_low), .cell_low(cell_low), .pin_level(pin_lvl),
    .rst_level(rst_lvl));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
    chk(n, e, rv & m);
  endtask : rd_chk

  // output picked after the wait, so the value seen is the settled one
  task automatic wait_chk(input string n, input int c, input logic e, input int s);
    logic g;
    repeat (c) @(posedge ref_clk);
    #1;
    case (s)
      S_WARN: g = warn;
      S_RST: g = rst_oe;
      S_PIN: g = pin_oe;
      default: g = irq;
    endcase
    chk(n, {7'h00, e}, {7'h00, g});
  endtask : wait_chk

  task automatic tick;
    @(posedge ref_clk);
    year_tick <= 1'b1;
    @(posedge ref_clk);
    year_tick <= 1'b0;
  endtask : tick

  // recovery length measured from supply rise to reset release
  task automatic power_up(input int len, input bit probe);
    longint t0;
    int cnt;
    @(posedge ref_clk);
    supply_req <= 1'b1;
    t0 = $time;
    if (probe) begin
      wait_chk("warn recov", 6, 1'b1, S_WARN);
      reg_wr(OFS_CENT, 8'hC0);
      reg_wr(OFS_CTRL, 8'h00);
    end
    for (int i = 0; i < 300 && rst_oe !== 1'b0; i++) begin
      @(posedge ref_clk);
      #1;
    end
    cnt = int'(($time - t0) / 4);
    chk("recov len", 8'h01, {7'h00, cnt >= len && cnt <= len + 8});
  endtask : power_up

  task automatic drop;
    @(posedge ref_clk);
    supply_req <= 1'b0;
    wait_chk("warn backup", 8, 1'b0, S_WARN);
    wait_chk("rst backup", 0, 1'b1, S_RST);
    chk("rst pin", 8'h00, {6'h00, rst_o, rst_lvl});
    chk("pin drive", 8'h00, {7'h00, pin_o});
  endtask : drop

  task automatic t_first;
    power_up(RB, 1'b1);
    wait_chk("warn fail", 4, 1'b0, S_WARN);
    fail_req <= 1'b0;
    wait_chk("warn ok", 6, 1'b1, S_WARN);
    chk("rst released", 8'h01, {7'h00, rst_lvl});
    rd_chk("cent refused", OFS_CENT, 8'hFF, 8'h00);
    rd_chk("trec", OFS_TREC, 8'h80, 8'h00);
    rd_chk("halt", OFS_HALT, 8'h80, 8'h80);
    rd_chk("ctrl", OFS_CTRL, 8'hC0, 8'h80);
    rd_chk("dog", OFS_DOG, 8'hFF, 8'h00);
    rd_chk("alarm", OFS_ALM, 8'hE0, 8'h00);
    rd_chk("htm", OFS_HTM, 8'h40, 8'h40);
    rd_chk("flag", OFS_FLAG, 8'hFF, 8'h11);
    rd_chk("unmapped", 8'h3F, 8'hFF, 8'h00);
    rd_chk("irq stat", OFS_IRQ_STAT, 8'h03, 8'h03);
  endtask : t_first

  task automatic t_pin;
    wait_chk("pin lvl1", 0, 1'b0, S_PIN);
    reg_wr(OFS_CTRL, 8'h00);
    wait_chk("pin low", 2, 1'b1, S_PIN);
    repeat (3) @(posedge ref_clk);
    rd_chk("pin seen", OFS_FLAG, 8'h01, 8'h00);
    reg_wr(OFS_CTRL, 8'h40);
    wait_chk("pin test", 2, 1'b0, S_PIN);
    reg_wr(OFS_CTRL, 8'h00);
    reg_wr(OFS_DOG, 8'h01);
    wait_chk("pin dog", 2, 1'b0, S_PIN);
    reg_wr(OFS_DOG, 8'h00);
    reg_wr(OFS_ALM, 8'h80);
    wait_chk("pin alarm", 2, 1'b0, S_PIN);
    reg_wr(OFS_ALM, 8'h00);
    wait_chk("pin back", 2, 1'b1, S_PIN);
    reg_wr(OFS_CTRL, 8'h80);
  endtask : t_pin

  task automatic t_century;
    reg_wr(OFS_YEAR, 8'h99);
    reg_wr(OFS_CENT, 8'h80);
    tick();
    rd_chk("cent flip", OFS_CENT, 8'hC0, 8'hC0);
    rd_chk("year wrap", OFS_YEAR, 8'hFF, 8'h00);
    reg_wr(OFS_YEAR, 8'h98);
    tick();
    rd_chk("cent no roll", OFS_CENT, 8'hC0, 8'hC0);
    tick();
    rd_chk("cent back", OFS_CENT, 8'hC0, 8'h80);
    reg_wr(OFS_CENT, 8'h40);
    reg_wr(OFS_YEAR, 8'h99);
    tick();
    rd_chk("cent held", OFS_CENT, 8'hC0, 8'h40);
  endtask : t_century

  task automatic t_irq;
    reg_wr(OFS_IRQ_EN, 8'h04);
    wait_chk("irq on", 2, 1'b1, S_IRQ);
    reg_wr(OFS_IRQ_EN, 8'h00);
    wait_chk("irq mask", 2, 1'b0, S_IRQ);
    reg_wr(OFS_IRQ_EN, 8'h04);
    reg_wr(OFS_IRQ_CLR, 8'h04);
    wait_chk("irq clr", 2, 1'b0, S_IRQ);
    rd_chk("stat clr", OFS_IRQ_STAT, 8'h04, 8'h00);
  endtask : t_irq

  task automatic t_daily;
    cell_req <= 1'b0;
    repeat (DAY + 20) @(posedge ref_clk);
    rd_chk("weak gone", OFS_FLAG, 8'h10, 8'h00);
    cell_req <= 1'b1;
    repeat (DAY + 20) @(posedge ref_clk);
    rd_chk("weak daily", OFS_FLAG, 8'h10, 8'h10);
  endtask : t_daily

  task automatic t_later;
    reg_wr(OFS_TREC, 8'h80);
    reg_wr(OFS_DOG, 8'hFF);
    reg_wr(OFS_ALM, 8'hE0);
    reg_wr(OFS_CTRL, 8'h40);
    drop();
    cell_req <= 1'b0;
    power_up(RC, 1'b0);
    rd_chk("trec kept", OFS_TREC, 8'h80, 8'h80);
    rd_chk("ctrl", OFS_CTRL, 8'hC0, 8'h00);
    rd_chk("dog clr", OFS_DOG, 8'hFF, 8'h00);
    rd_chk("alarm clr", OFS_ALM, 8'hE0, 8'h00);
    rd_chk("htm", OFS_HTM, 8'h40, 8'h40);
    rd_chk("halt kept", OFS_HALT, 8'h80, 8'h80);
    rd_chk("flag", OFS_FLAG, 8'hFF, 8'h00);
    reg_wr(OFS_TREC, 8'h00);
    reg_wr(OFS_HALT, 8'h00);
    drop();
    power_up(RA, 1'b0);
  endtask : t_later

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // bound on the whole run, well above the expected length
  initial begin
    #(4 * 4000);
    mismatches++;
    report_and_stop();
  end

  initial begin
    {rst_b, year_tick, wr, rd, supply_req, fail_req, cell_req} = 7'b0000011;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_first();
    t_pin();
    t_century();
    t_irq();
    t_daily();
    t_later();
    report_and_stop();
  end
endmodule : testbench
